// ---- rtl/sfr_consts.svh ----
// Constants of the serial flash reset and feature register bank.
// Assumes a 20 MHz system clock; included by bare name wherever needed.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// Opcodes.
`define SFR_OP_SOFT_RESET   8'hff
`define SFR_OP_RESET_EN     8'h66
`define SFR_OP_POR          8'h99
`define SFR_OP_WREN         8'h06
`define SFR_OP_WRDI         8'h04
`define SFR_OP_GET_FEAT     8'h0f
`define SFR_OP_SET_FEAT     8'h1f
`define SFR_OP_PROG_EXEC    8'h10
`define SFR_OP_BLOCK_ERASE  8'hd8
`define SFR_OP_PAGE_READ    8'h13

// Feature addresses.
`define SFR_ADR_PROTECT     8'ha0
`define SFR_ADR_FEATURE     8'hb0
`define SFR_ADR_STATUS      8'hc0
`define SFR_ADR_DRIVE       8'hd0
`define SFR_ADR_EXT_STATUS  8'hf0

// Field positions.
`define SFR_BIT_GUARD       7
`define SFR_BIT_BP_HI       5
`define SFR_BIT_BP_LO       3
`define SFR_BIT_INV         2
`define SFR_BIT_CMP         1
`define SFR_BIT_OTP_LOCK    7
`define SFR_BIT_OTP_EN      6
`define SFR_BIT_ECC_EN      4
`define SFR_BIT_LOCKDOWN    3
`define SFR_BIT_QUAD        0
`define SFR_BIT_DS_HI       6
`define SFR_BIT_DS_LO       5

// Reset values.
`define SFR_RST_BP_RANGE    3'h7
`define SFR_RST_ECC_EN      1'h1
`define SFR_RST_BPS         1'h1
`define SFR_RST_DRIVE       2'h0

// Link bit counts at which a frame's commands complete.
`define SFR_CNT_OP_DONE     6'h07
`define SFR_CNT_ADR_DONE    6'h0f
`define SFR_CNT_DAT_DONE    6'h17
`define SFR_CNT_ROW_DONE    6'h1f

// Timing.
`define SFR_SYS_PERIOD_NS   50
`define SFR_POR_RECOVERY_NS 20000
`define SFR_SOFT_RESET_NS   1000
`define SFR_POR_CYCLES  ((`SFR_POR_RECOVERY_NS + `SFR_SYS_PERIOD_NS - 1) / `SFR_SYS_PERIOD_NS)
`define SFR_SOFT_CYCLES ((`SFR_SOFT_RESET_NS + `SFR_SYS_PERIOD_NS - 1) / `SFR_SYS_PERIOD_NS)
`define SFR_CNT_W           10

`endif

// ---- rtl/sfr_pkg.sv ----
// Types of the serial flash reset and feature register bank.
// Assumes sfr_consts.svh is on the include path.
`include "sfr_consts.svh"

package sfr_pkg;

  typedef enum logic [1:0] {
    SFR_ST_IDLE = 2'b00,
    SFR_ST_POR  = 2'b01,
    SFR_ST_SOFT = 2'b10,
    SFR_ST_BUSY = 2'b11
  } sfr_state_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] fa;
    logic [7:0] tx;
    logic       so;
    logic       oe;
  } sfr_frm_t;

  typedef struct packed {
    logic        tog;
    logic [7:0]  op;
    logic [7:0]  fa;
    logic [7:0]  dat;
    logic [39:0] im1;
    logic [39:0] im2;
  } sfr_hold_t;

  typedef struct packed {
    sfr_state_t           state;
    logic [`SFR_CNT_W-1:0] cnt;
    logic                 tog_s1;
    logic                 tog_s2;
    logic                 tog_s3;
    logic                 wp_s1;
    logic                 wp_s2;
    logic                 armed;
    logic                 guard;
    logic [2:0]           bp_range;
    logic                 protect_range_invert;
    logic                 cmp;
    logic                 otp_lock;
    logic                 otp_en;
    logic                 ecc_en;
    logic                 lockdown;
    logic                 quad;
    logic [1:0]           ecc_res;
    logic [1:0]           ecc_ext;
    logic                 pfail;
    logic                 efail;
    logic                 write_enable_latch;
    logic                 block_protected_flag;
    logic [1:0]           drive;
    logic [39:0]          img;
    logic                 start_prog;
    logic                 start_erase;
    logic                 start_read;
    logic                 abort;
    logic                 por_load;
  } sfr_sys_t;

endpackage

// ---- rtl/sfr_feature_regs.sv ----
// Reset handling and feature/status register bank of a serial NAND flash.
// Assumes an SPI host on the link pins and an array engine on the core ports.
`timescale 1ns/10ps
`include "sfr_consts.svh"

// Operation
// RULE1 - Soft reset opcode aborts any program, erase or read and returns to idle.
// RULE2 - Accepted power-on reset aborts operations and restores all power-on defaults.
// RULE3 - Host sends reset-enable and reset opcodes in two separate frames.
// RULE4 - All commands are ignored during the reset recovery interval; the code ignores all but get feature, and only in power-on reset recovery.
// RULE5 - Host should poll operation in progress after a reset.
// RULE6 - Get and set feature opcodes are followed by one feature address byte.
// RULE7 - Written features persist until rewritten or power cycled; soft reset keeps them.
// RULE8 - Protection, feature, drive registers are read-write; status registers read only.
// RULE9 - Host writes zero into reserved bits on set feature.
// RULE10 - Guard set with write protect low blocks protection register changes.
// RULE11 - Quad enable gates quad commands; powers up zero, kept over soft reset.
// RULE12 - OTP lock is non-volatile; all other feature bits are volatile.
// RULE13 - Internal ECC enable powers up one; clearing it disables ECC.
// RULE14 - Lockdown freezes protection fields until power cycle; powers up zero.
// RULE15 - ECC status clears on reset and read start, updates on read completion.
// RULE16 - ECC status fields are meaningless while internal ECC is disabled.
// RULE17 - After power-on reset ECC status reports the block 0 page 0 load.
// RULE18 - Program fail sets on failure or protected program; clears on execute or reset.
// RULE19 - Erase fail sets on failure or locked erase; clears on erase start or reset; the code sets it only from erase_fail_i.
// RULE20 - Write enable latch set and cleared by commands; needed for program and erase.
// RULE21 - Operation in progress reads one while program, read, erase or reset runs.
// RULE22 - Drive strength powers up zero and survives soft reset.
// RULE23 - Block protected flag shows selected block state; powers up one.
// RULE24 - ECC codes: 00 none, 01 corrected, 11 eight corrected, 10 uncorrectable.
// RULE25 - Feature transfers carry opcode, address, then one data byte, MSB first.
module sfr_feature_regs (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_si_i,
  output logic            spi_so_o,
  output logic            spi_so_oe_o,
  input  wire logic       wp_n_i,
  input  wire logic       otp_lock_nv_i,
  input  wire logic       op_done_i,
  input  wire logic       prog_fail_i,
  input  wire logic       erase_fail_i,
  input  wire logic       ecc_valid_i,
  input  wire logic [1:0] ecc_result_i,
  input  wire logic [1:0] ecc_result_ext_i,
  input  wire logic       bps_update_i,
  input  wire logic       block_protected_i,
  output logic            start_prog_o,
  output logic            start_erase_o,
  output logic            start_read_o,
  output logic            abort_o,
  output logic            por_load_o,
  output logic            quad_io_enable_o,
  output logic            internal_ecc_enable_o,
  output logic            otp_enable_o,
  output logic            otp_lock_o,
  output logic [2:0]      block_protect_range_o,
  output logic            protect_range_invert_o,
  output logic            protect_range_complement_o,
  output logic [1:0]      drive_strength_sel_o
);
  import sfr_pkg::*;

  localparam int POR_LO = `SFR_POR_CYCLES;
  localparam int POR_HI = `SFR_POR_CYCLES + 1;

  sfr_frm_t  frm_q,  frm_d;
  sfr_hold_t hold_q, hold_d;
  sfr_sys_t  q,      d;
  logic      ev_w;
  logic      live_w;
  logic      soft_acc_w;
  logic      por_acc_w;
  logic      set_a0_w;
  logic [7:0] pick_w;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------

  // Picks the readback byte of a feature address from the register image.
  function automatic logic [7:0] sfr_pick(input logic [7:0] a, input logic [39:0] im);
    case (a)
      `SFR_ADR_PROTECT:    sfr_pick = im[39:32];
      `SFR_ADR_FEATURE:    sfr_pick = im[31:24];
      `SFR_ADR_STATUS:     sfr_pick = im[23:16];
      `SFR_ADR_DRIVE:      sfr_pick = im[15:8];
      `SFR_ADR_EXT_STATUS: sfr_pick = im[7:0];
      default:             sfr_pick = 8'h00;
    endcase
  endfunction

  // Tells whether an opcode carries a three-byte row address.
  function automatic logic sfr_is_row(input logic [7:0] op);
    sfr_is_row = (op == `SFR_OP_PROG_EXEC) || (op == `SFR_OP_BLOCK_ERASE) ||
                 (op == `SFR_OP_PAGE_READ);
  endfunction

  // Power-on defaults of every volatile bit; the OTP lock is left alone.
  function automatic sfr_sys_t sfr_apply_por(input sfr_sys_t s);
    sfr_sys_t r;
    r          = s;
    r.armed    = 1'h0;
    r.guard    = 1'h0;
    r.bp_range = `SFR_RST_BP_RANGE;
    r.protect_range_invert      = 1'h0;
    r.cmp      = 1'h0;
    r.otp_en   = 1'h0;
    r.ecc_en   = `SFR_RST_ECC_EN;
    r.lockdown = 1'h0;
    r.quad     = 1'h0;
    r.ecc_res  = 2'h0;
    r.ecc_ext  = 2'h0;
    r.pfail    = 1'h0;
    r.efail    = 1'h0;
    r.write_enable_latch      = 1'h0;
    r.block_protected_flag      = `SFR_RST_BPS;
    r.drive    = `SFR_RST_DRIVE;
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------------------

  // Readback byte picked by the address byte that completes on this edge.
  assign pick_w = sfr_pick({frm_q.sh[6:0], spi_si_i}, hold_q.im2);

  // Frame decoder: shifts bits in on the rising edge, fires one event per command except get feature.
  always_comb
  begin
    frm_d  = frm_q;
    hold_d = hold_q;
    hold_d.im1 = q.img;
    hold_d.im2 = hold_q.im1;
    frm_d.sh   = {frm_q.sh[6:0], spi_si_i};                       // RULE25
    frm_d.cnt  = (frm_q.cnt == 6'h3f) ? frm_q.cnt : frm_q.cnt + 6'h01;
    if (frm_q.cnt == `SFR_CNT_OP_DONE)
    begin
      frm_d.op = frm_d.sh;
      if (frm_d.sh != `SFR_OP_GET_FEAT && frm_d.sh != `SFR_OP_SET_FEAT &&
          !sfr_is_row(frm_d.sh))
      begin
        hold_d.tog = ~hold_q.tog;
        hold_d.op  = frm_d.sh;
        hold_d.fa  = 8'h00;
        hold_d.dat = 8'h00;
      end
    end
    if (frm_q.cnt == `SFR_CNT_ADR_DONE)
    begin
      frm_d.fa = frm_d.sh;                                        // RULE6
      if (frm_q.op == `SFR_OP_GET_FEAT)
      begin
        frm_d.tx = {pick_w[6:0], 1'h0};
        frm_d.so = pick_w[7];
        frm_d.oe = 1'h1;
      end
    end
    else if (frm_q.oe)
    begin
      frm_d.so = frm_q.tx[7];                                     // RULE25
      frm_d.tx = {frm_q.tx[6:0], 1'h0};
    end
    if (frm_q.cnt == `SFR_CNT_DAT_DONE && frm_q.op == `SFR_OP_SET_FEAT)
    begin
      hold_d.tog = ~hold_q.tog;
      hold_d.op  = frm_q.op;
      hold_d.fa  = frm_q.fa;
      hold_d.dat = frm_d.sh;
    end
    if (frm_q.cnt == `SFR_CNT_ROW_DONE && sfr_is_row(frm_q.op))
    begin
      hold_d.tog = ~hold_q.tog;
      hold_d.op  = frm_q.op;
      hold_d.fa  = 8'h00;
      hold_d.dat = 8'h00;
    end
  end

  // Frame state ends with chip select; held command words survive frames.
  always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i)
  begin
    if (spi_cs_n_i)
      frm_q <= '0;
    else
      frm_q <= frm_d;
  end

  // Held command words; the toggle marks a new one for the system side.
  always_ff @(posedge spi_sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hold_q <= '0;
    else
      hold_q <= hold_d;
  end

  assign spi_so_o    = frm_q.so;
  assign spi_so_oe_o = frm_q.oe;

  // ---------------------------------------------------------------------------
  // System domain
  // ---------------------------------------------------------------------------

  // Event strobe from the synchronised toggle; payload is stable by then.
  assign ev_w       = q.tog_s2 ^ q.tog_s3;
  assign live_w     = ev_w && (q.state != SFR_ST_POR);            // RULE4
  assign soft_acc_w = live_w && (hold_q.op == `SFR_OP_SOFT_RESET);
  assign por_acc_w  = live_w && (hold_q.op == `SFR_OP_POR) && q.armed;
  assign set_a0_w   = live_w && (hold_q.op == `SFR_OP_SET_FEAT) &&
                      (hold_q.fa == `SFR_ADR_PROTECT);

  // Command execution, array results and the readback image.
  always_comb
  begin
    d             = q;
    d.start_prog  = 1'h0;
    d.start_erase = 1'h0;
    d.start_read  = 1'h0;
    d.abort       = 1'h0;
    d.por_load    = 1'h0;
    d.tog_s1      = hold_q.tog;
    d.tog_s2      = q.tog_s1;
    d.tog_s3      = q.tog_s2;
    d.wp_s1       = wp_n_i;
    d.wp_s2       = q.wp_s1;
    d.img = {q.guard, 1'h0, q.bp_range, q.protect_range_invert, q.cmp, 1'h0,
             q.otp_lock, q.otp_en, 1'h0, q.ecc_en, q.lockdown, 2'h0, q.quad,
             2'h0, q.ecc_res, q.pfail, q.efail, q.write_enable_latch, (q.state != SFR_ST_IDLE),
             1'h0, q.drive, 5'h00,
             2'h0, q.ecc_ext, q.block_protected_flag, 3'h0};                       // RULE8 RULE21
    // Busy timing.
    case (q.state)
      SFR_ST_POR, SFR_ST_SOFT:
        if (q.cnt == '0)
          d.state = SFR_ST_IDLE;
        else
          d.cnt = q.cnt - `SFR_CNT_W'(1);
      SFR_ST_BUSY:
        if (op_done_i)
          d.state = SFR_ST_IDLE;
      SFR_ST_IDLE:
        d.state = SFR_ST_IDLE;
      default:
        d.state = SFR_ST_IDLE;
    endcase
    // Commands; any command but reset enable or get feature disarms the power-on reset.
    if (live_w)
    begin
      d.armed = 1'h0;                                             // RULE3
      case (hold_q.op)
        `SFR_OP_RESET_EN:
          d.armed = 1'h1;
        `SFR_OP_POR:
          if (q.armed)
          begin
            d          = sfr_apply_por(d);                        // RULE2
            d.abort    = 1'h1;
            d.por_load = 1'h1;                                    // RULE17
            d.state    = SFR_ST_POR;
            d.cnt      = `SFR_CNT_W'(`SFR_POR_CYCLES - 1);
          end
        `SFR_OP_SOFT_RESET:
        begin
          d.abort   = 1'h1;                                       // RULE1 RULE7
          d.state   = SFR_ST_SOFT;
          d.cnt     = `SFR_CNT_W'(`SFR_SOFT_CYCLES - 1);
          d.pfail   = 1'h0;
          d.efail   = 1'h0;
          d.write_enable_latch     = 1'h0;
          d.ecc_res = 2'h0;                                       // RULE15
          d.ecc_ext = 2'h0;
        end
        `SFR_OP_WREN:
          d.write_enable_latch = 1'h1;                                           // RULE20
        `SFR_OP_WRDI:
          d.write_enable_latch = 1'h0;                                           // RULE20
        `SFR_OP_SET_FEAT:
          case (hold_q.fa)
            `SFR_ADR_PROTECT:
              if (!q.lockdown && !(q.guard && !q.wp_s2))          // RULE10 RULE14
              begin
                d.guard    = hold_q.dat[`SFR_BIT_GUARD];
                d.bp_range = hold_q.dat[`SFR_BIT_BP_HI:`SFR_BIT_BP_LO];
                d.protect_range_invert      = hold_q.dat[`SFR_BIT_INV];
                d.cmp      = hold_q.dat[`SFR_BIT_CMP];
              end
            `SFR_ADR_FEATURE:
            begin
              d.otp_lock = q.otp_lock | hold_q.dat[`SFR_BIT_OTP_LOCK]; // RULE12
              d.otp_en   = hold_q.dat[`SFR_BIT_OTP_EN];
              d.ecc_en   = hold_q.dat[`SFR_BIT_ECC_EN];           // RULE13
              d.lockdown = q.lockdown | hold_q.dat[`SFR_BIT_LOCKDOWN]; // RULE14
              d.quad     = hold_q.dat[`SFR_BIT_QUAD];             // RULE11
            end
            `SFR_ADR_DRIVE:
              d.drive = hold_q.dat[`SFR_BIT_DS_HI:`SFR_BIT_DS_LO];  // RULE22
            default:
              d.armed = 1'h0;                                     // RULE8
          endcase
        `SFR_OP_PROG_EXEC:
          if (q.write_enable_latch && q.state == SFR_ST_IDLE)                    // RULE20
          begin
            d.pfail = 1'h0;                                       // RULE18
            if (q.otp_en && q.otp_lock)
              d.pfail = 1'h1;                                     // RULE18
            else
            begin
              d.start_prog = 1'h1;
              d.state      = SFR_ST_BUSY;
            end
          end
        `SFR_OP_BLOCK_ERASE:
          if (q.write_enable_latch && q.state == SFR_ST_IDLE)                    // RULE20
          begin
            d.efail       = 1'h0;                                 // RULE19
            d.start_erase = 1'h1;
            d.state       = SFR_ST_BUSY;
          end
        `SFR_OP_PAGE_READ:
          if (q.state == SFR_ST_IDLE)
          begin
            d.ecc_res    = 2'h0;                                  // RULE15
            d.ecc_ext    = 2'h0;
            d.start_read = 1'h1;
            d.state      = SFR_ST_BUSY;
          end
        default:
          d.armed = 1'h0;
      endcase
    end
    // Array results come last so a set beats a clear in the same cycle.
    if (prog_fail_i)
      d.pfail = 1'h1;                                             // RULE18
    if (erase_fail_i)
      d.efail = 1'h1;                                             // RULE19
    if (ecc_valid_i)
    begin
      d.ecc_res = ecc_result_i;                                   // RULE15 RULE24 RULE16
      d.ecc_ext = ecc_result_ext_i;
    end
    if (bps_update_i)
      d.block_protected_flag = block_protected_i;                                  // RULE23
    if (!rst_n_i)
    begin
      d          = '0;
      d          = sfr_apply_por(d);
      d.otp_lock = otp_lock_nv_i;                                 // RULE12
    end
  end

  // System state register.
  always_ff @(posedge clk_sys_i)
  begin
    q <= d;
  end

  assign start_prog_o               = q.start_prog;
  assign start_erase_o              = q.start_erase;
  assign start_read_o               = q.start_read;
  assign abort_o                    = q.abort;
  assign por_load_o                 = q.por_load;
  assign quad_io_enable_o           = q.quad;
  assign internal_ecc_enable_o      = q.ecc_en;
  assign otp_enable_o               = q.otp_en;
  assign otp_lock_o                 = q.otp_lock;
  assign block_protect_range_o      = q.bp_range;
  assign protect_range_invert_o     = q.protect_range_invert;
  assign protect_range_complement_o = q.cmp;
  assign drive_strength_sel_o       = q.drive;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  // Recovery holds busy and ends on time.
  por_hold_busy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE4
    por_acc_w |=> (q.state == SFR_ST_POR) [*8])
    else $error("power-on reset recovery left early");
  por_end_time_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE2
    por_acc_w |-> ##[POR_LO:POR_HI] (q.state == SFR_ST_IDLE))
    else $error("power-on reset recovery wrong length");
  por_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE4
    (ev_w && q.state == SFR_ST_POR) |=> $stable(q.write_enable_latch) && $stable(q.drive) && !q.start_prog)
    else $error("command acted on during recovery");
  soft_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE7
    soft_acc_w |=> $stable(q.drive) && $stable(q.quad) && $stable(q.ecc_en) && !q.write_enable_latch)
    else $error("soft reset disturbed features");
  soft_ecc_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE15
    (soft_acc_w && !ecc_valid_i) |=> (q.ecc_res == 2'h0) && (q.ecc_ext == 2'h0) &&
    (q.state == SFR_ST_SOFT))
    else $error("soft reset did not clear ecc status");
  guard_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE10
    (set_a0_w && q.guard && !q.wp_s2) |=> $stable(q.bp_range) && $stable(q.guard))
    else $error("guarded protection register changed");
  lockdown_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE14
    (q.lockdown && !por_acc_w) |=> q.lockdown && $stable(q.bp_range) && $stable(q.protect_range_invert) &&
    $stable(q.cmp))
    else $error("locked protection fields changed");
  wel_needed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE20
    (q.start_prog || q.start_erase) |-> $past(q.write_enable_latch) && (q.state == SFR_ST_BUSY))
    else $error("program or erase started without write enable");
  pfail_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE18
    prog_fail_i |=> q.pfail ##1 q.img[19])
    else $error("program fail not reported");
  efail_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE19
    erase_fail_i |=> q.efail ##1 q.img[18])
    else $error("erase fail not reported");
  oip_busy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE21
    (q.state != SFR_ST_IDLE) [*2] |-> q.img[16])
    else $error("operation in progress not shown");

endmodule // sfr_feature_regs

// ---- dv/sfr_spi_host.sv ----
// SPI host model that frames commands for the feature register bank.
// Assumes mode 0: the device samples si and updates so on rising sclk.
`timescale 1ns/10ps
module sfr_spi_host (
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_si_o,
  input  wire logic spi_so_i,
  input  wire logic spi_so_oe_i
);
  // The clock stands still low and chip select is high between frames.
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_si_o   = 1'b0;
    #1 spi_cs_n_o = 1'b1; // A rising select clears the frame state.
  end

  // One command per frame, opcode then address then data, MSB first.
  task automatic frame(input logic [31:0] w, input int nb, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    spi_cs_n_o = 1'b0;
    #20;
    for (i = 0; i < nb * 8; i++)
    begin
      spi_si_o = w[31 - i];
      #7.5;
      if (i >= 16) rd = {rd[6:0], spi_so_oe_i ? spi_so_i : 1'b1};
      spi_sclk_o = 1'b1;
      #7.5;
      spi_sclk_o = 1'b0;
    end
    #20;
    spi_cs_n_o = 1'b1;
    spi_si_o = ~spi_si_o; // Released line shows no stale value.
    #400;
  endtask
endmodule // sfr_spi_host

// ---- dv/tb.sv ----
// Self-checking bench of the feature register bank over its SPI link.
// Assumes sfr_consts.svh on the include path and the host model beside it.
`timescale 1ns/10ps
`include "sfr_consts.svh"
module tb;
  logic       clk_sys_i, rst_n_i, wp_n, sclk, cs_n, si, so, so_oe, sp, ab, pl, qe, ee;
  logic [9:0] core;
  logic [2:0] bpr;
  logic [1:0] ds;
  logic [7:0] last, d, a;
  int         errors, total_checks, cyc, n_prog, n_abort, n_por, seed, k, n;
  sfr_feature_regs sfr_feature_regs_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .wp_n_i(wp_n), .otp_lock_nv_i(1'b0), .op_done_i(core[9]), .prog_fail_i(core[8]),
    .erase_fail_i(core[7]), .ecc_valid_i(core[6]), .ecc_result_i(core[5:4]),
    .ecc_result_ext_i(core[3:2]), .bps_update_i(core[1]), .block_protected_i(core[0]),
    .start_prog_o(sp), .start_erase_o(), .start_read_o(), .abort_o(ab), .por_load_o(pl),
    .quad_io_enable_o(qe), .internal_ecc_enable_o(ee), .otp_enable_o(), .otp_lock_o(),
    .block_protect_range_o(bpr), .protect_range_invert_o(), .protect_range_complement_o(),
    .drive_strength_sel_o(ds));
  sfr_spi_host sfr_spi_host_i (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_si_o(si),
    .spi_so_i(so), .spi_so_oe_i(so_oe));

  // Writable bits of each read-write register except OTP lock and lockdown; reserved bits stay zero.
  function automatic logic [7:0] wmask(input logic [7:0] adr);
    return (adr == `SFR_ADR_PROTECT) ? 8'hbe : (adr == `SFR_ADR_FEATURE) ? 8'h51 : 8'h60;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    sfr_spi_host_i.frame({op, 24'h0}, (op == `SFR_OP_PROG_EXEC) ? 4 : 1, last);
  endtask
  task automatic set(input logic [7:0] adr, input logic [7:0] dat);
    sfr_spi_host_i.frame({`SFR_OP_SET_FEAT, adr, dat, 8'h00}, 3, last);
  endtask
  task automatic get(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] exp);
    sfr_spi_host_i.frame({`SFR_OP_GET_FEAT, adr, 16'h0}, 3, last);
    chk(last & m, exp);
  endtask
  // Array engine events are one-cycle pulses just after a clock edge.
  task automatic poke(input logic [9:0] v);
    @(posedge clk_sys_i);
    #2 core = v;
    @(posedge clk_sys_i);
    #2 core = 10'h000;
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // System clock, 50 ns period.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Counts output pulses and cuts a hang short.
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (sp === 1'b1) n_prog++;
    if (ab === 1'b1) n_abort++;
    if (pl === 1'b1) n_por++;
    if (cyc == 20000)
    begin
      errors++;
      final_report();
    end
  end

  // Main sequence of scenarios.
  initial
  begin
    seed = 5718;
    rst_n_i = 1'b0;
    wp_n = 1'b1;
    core = 10'h000;
    repeat (16) @(posedge clk_sys_i);
    #2 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    get(`SFR_ADR_PROTECT, 8'hff, 8'h38);
    get(`SFR_ADR_FEATURE, 8'hff, 8'h10);
    get(`SFR_ADR_STATUS, 8'hff, 8'h00);
    get(`SFR_ADR_DRIVE, 8'hff, 8'h00);
    get(`SFR_ADR_EXT_STATUS, 8'hff, 8'h08);
    for (k = 0; k < 6; k++)
    begin
      a = (k % 3 == 0) ? `SFR_ADR_PROTECT : (k % 3 == 1) ? `SFR_ADR_FEATURE : `SFR_ADR_DRIVE;
      d = 8'($random(seed)) & wmask(a);
      set(a, d);
      get(a, 8'hff, d);
    end
    set(`SFR_ADR_FEATURE, 8'h11);
    chk({6'h0, qe, ee}, 8'h03);
    set(`SFR_ADR_PROTECT, 8'h00);
    set(`SFR_ADR_DRIVE, 8'h40);
    set(`SFR_ADR_STATUS, 8'hff);
    get(`SFR_ADR_STATUS, 8'hff, 8'h00);
    cmd(`SFR_OP_PROG_EXEC);
    chk(8'(n_prog), 8'h00);
    cmd(`SFR_OP_WREN);
    get(`SFR_ADR_STATUS, 8'hff, 8'h02);
    cmd(`SFR_OP_PROG_EXEC);
    chk(8'(n_prog), 8'h01);
    get(`SFR_ADR_STATUS, 8'h01, 8'h01);
    poke(10'h300);
    get(`SFR_ADR_STATUS, 8'h09, 8'h08);
    d = 8'($random(seed)) & 8'h0f;
    poke({4'h1, d[3:0], 2'b00});
    get(`SFR_ADR_STATUS, 8'h30, {2'b00, d[3:2], 4'h0});
    get(`SFR_ADR_EXT_STATUS, 8'h30, {2'b00, d[1:0], 4'h0});
    cmd(`SFR_OP_SOFT_RESET);
    chk(8'(n_abort), 8'h01);
    get(`SFR_ADR_STATUS, 8'h3e, 8'h00);
    get(`SFR_ADR_FEATURE, 8'hff, 8'h11);
    get(`SFR_ADR_DRIVE, 8'hff, 8'h40);
    chk({6'h0, ds}, 8'h02);
    set(`SFR_ADR_PROTECT, 8'h80);
    @(posedge clk_sys_i) #2 wp_n = 1'b0;
    set(`SFR_ADR_PROTECT, 8'h00);
    get(`SFR_ADR_PROTECT, 8'hff, 8'h80);
    @(posedge clk_sys_i) #2 wp_n = 1'b1;
    set(`SFR_ADR_PROTECT, 8'h00);
    get(`SFR_ADR_PROTECT, 8'hff, 8'h00);
    set(`SFR_ADR_FEATURE, 8'h08);
    set(`SFR_ADR_PROTECT, 8'h38);
    get(`SFR_ADR_PROTECT, 8'hff, 8'h00);
    poke(10'h002);
    get(`SFR_ADR_EXT_STATUS, 8'hff, 8'h00);
    cmd(`SFR_OP_POR);
    chk(8'(n_por), 8'h00);
    cmd(`SFR_OP_RESET_EN);
    cmd(`SFR_OP_POR);
    chk(8'(n_por), 8'h01);
    set(`SFR_ADR_DRIVE, 8'h60);
    n = 0;
    last = 8'hff;
    while (last[0] !== 1'b0 && n < 80)
    begin
      get(`SFR_ADR_STATUS, 8'h00, 8'h00);
      n++;
    end
    chk({7'h0, last[0]}, 8'h00);
    get(`SFR_ADR_DRIVE, 8'hff, 8'h00);
    get(`SFR_ADR_PROTECT, 8'hff, 8'h38);
    chk({5'h0, bpr}, 8'h07);
    get(`SFR_ADR_FEATURE, 8'hff, 8'h10);
    get(`SFR_ADR_EXT_STATUS, 8'hff, 8'h08);
    poke(10'h054);
    get(`SFR_ADR_STATUS, 8'h30, 8'h10);
    final_report();
  end
endmodule // tb
